/* logic/dp_pkg.sv */
// constants shared by the data processing datapath and its barrel shifter
// assumes a 32-bit word and the core's own decoder as the only source
package dp_pkg;

   // ----------------------------------------------------------------------
   // instruction fields
   // ----------------------------------------------------------------------
   localparam int IMM_BIT = 25;
   localparam int OPC_HI = 24;
   localparam int OPC_LO = 21;
   localparam int SET_BIT = 20;
   localparam int FIRST_HI = 19;
   localparam int FIRST_LO = 16;
   localparam int DEST_HI = 15;
   localparam int DEST_LO = 12;
   localparam int AMT_REG_HI = 11;
   localparam int AMT_REG_LO = 8;
   localparam int ROT_HI = 11;
   localparam int ROT_LO = 8;
   localparam int SHAMT_HI = 11;
   localparam int SHAMT_LO = 7;
   localparam int MUL_SEL_BIT = 7;
   localparam int KIND_HI = 6;
   localparam int KIND_LO = 5;
   localparam int REG_SHIFT_BIT = 4;
   localparam int SECOND_HI = 3;
   localparam int SECOND_LO = 0;
   localparam int IMM8_HI = 7;
   localparam int IMM8_LO = 0;

   // ----------------------------------------------------------------------
   // opcodes and shift kinds
   // ----------------------------------------------------------------------
   localparam logic [3:0] OPC_AND = 4'h0;
   localparam logic [3:0] OPC_XOR = 4'h1;
   localparam logic [3:0] OPC_SUB = 4'h2;
   localparam logic [3:0] OPC_RSUB = 4'h3;
   localparam logic [3:0] OPC_ADD = 4'h4;
   localparam logic [3:0] OPC_ADDC = 4'h5;
   localparam logic [3:0] OPC_SUBC = 4'h6;
   localparam logic [3:0] OPC_RSUBC = 4'h7;
   localparam logic [3:0] OPC_TEST_BITS = 4'h8;
   localparam logic [3:0] OPC_TEST_EQUIV = 4'h9;
   localparam logic [3:0] OPC_COMPARE = 4'ha;
   localparam logic [3:0] OPC_COMPARE_NEG = 4'hb;
   localparam logic [3:0] OPC_OR = 4'hc;
   localparam logic [3:0] OPC_MOVE = 4'hd;
   localparam logic [3:0] OPC_BIT_CLEAR = 4'he;
   localparam logic [3:0] OPC_MOVE_NOT = 4'hf;
   localparam logic [1:0] TEST_GROUP = 2'h2;

   localparam logic [1:0] SHIFT_LEFT = 2'h0;
   localparam logic [1:0] SHIFT_RIGHT = 2'h1;
   localparam logic [1:0] SHIFT_ARITH = 2'h2;
   localparam logic [1:0] SHIFT_ROTATE = 2'h3;
   localparam logic [7:0] SHIFT_FULL_WORD = 8'h20;
   localparam logic [5:0] ROTATE_FULL_WORD = 6'h20;

   // ----------------------------------------------------------------------
   // registers, status word and timing
   // ----------------------------------------------------------------------
   localparam logic [3:0] PC_INDEX = 4'hf;
   localparam logic [31:0] PC_AHEAD_IMM = 32'h0000_0008;
   localparam logic [31:0] PC_AHEAD_REG = 32'h0000_000c;
   localparam int FLAG_N = 31;
   localparam int FLAG_Z = 30;
   localparam int FLAG_C = 29;
   localparam int FLAG_V = 28;
   localparam int MODE_HI = 4;
   localparam int MODE_LO = 0;
   localparam logic [4:0] MODE_USER = 5'h10;
   localparam logic [31:0] STATUS_RESET = 32'h0000_00d3;
   localparam logic [1:0] FETCHES_NORMAL = 2'h1;
   localparam logic [1:0] FETCHES_PC_WRITE = 2'h3;
   localparam logic [1:0] REFILL_CYCLES = FETCHES_PC_WRITE - FETCHES_NORMAL;
   localparam logic [1:0] REFILL_LAST = 2'h1;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_INTERNAL = 4'h2,
      ST_EXEC = 4'h4,
      ST_REFILL = 4'h8
   } dp_state_e;

endpackage

/* logic/barrel_shifter.sv */
// barrel shifter for the second operand: four shift kinds plus the
// one-bit extended rotate; purely combinational
// assumes the caller has already mapped encoded special amounts
`timescale 1ns/10ps

module barrel_shifter (
   // operand and control
   input wire logic [31:0] value,
   input wire logic [1:0] kind,
   input wire logic [7:0] amount,
   input wire logic extend,
   input wire logic carry_in,
   // shifted operand
   output logic [31:0] result,
   output logic carry_out
);

   logic [32:0] left_w;
   logic [32:0] right_w;
   logic [32:0] arith_w;
   logic [5:0] rot_amount;
   logic [63:0] rot_w;

   // ----------------------------------------------------------------------
   // shift paths; the spare bit carries the last bit shifted out
   // ----------------------------------------------------------------------
   assign left_w = {1'b0, value} << amount;
   assign right_w = {value, 1'b0} >> amount;
   assign arith_w = $signed({value, 1'b0}) >>> amount;
   // multiples of 32 rotate by a full word
   assign rot_amount = (amount[4:0] == 5'h00) ? dp_pkg::ROTATE_FULL_WORD
                       : {1'b0, amount[4:0]};
   assign rot_w = {value, value} >> rot_amount;

   always_comb begin
      result = value;
      carry_out = carry_in;
      if (extend) begin
         result = {carry_in, value[31:1]};
         carry_out = value[0];
      end else if (amount != 8'h00) begin
         case (kind)
            dp_pkg::SHIFT_LEFT: begin
               result = left_w[31:0];
               carry_out = left_w[32];
            end
            dp_pkg::SHIFT_RIGHT: begin
               result = right_w[32:1];
               carry_out = right_w[0];
            end
            dp_pkg::SHIFT_ARITH: begin
               result = arith_w[32:1];
               carry_out = arith_w[0];
            end
            default: begin
               result = rot_w[31:0];
               carry_out = rot_w[31];
            end
         endcase
      end
   end

endmodule

/* logic/data_processing_unit.sv */
// execution datapath for data processing instructions: operand fetch
// with program counter view, shifter, alu, flags and status restore
// assumes the decoder offers only data processing class words and that
// register read data are valid in the cycle the instruction is issued
`timescale 1ns/10ps

// Overview of operation
// - register shift amount uses low byte only
// - register amount zero passes operand, old carry
// - amounts 1 to 31 match encoded shifts
// - left by 32 carry bit0, beyond zero
// - right by 32 carry bit31, beyond zero
// - arithmetic 32 or more fills with sign
// - rotate by 32 returns operand, carry bit31
// - rotate above 32 reduces modulo 32
// - bit 7 set with register shift means not data operation
// - immediate zero-extended, rotated by twice field
// - non-pc destination may update flags
// - pc destination without set keeps status
// - pc destination with set restores status
// - pc operand is address plus 8 or 12
// - test opcodes never write, set flags except legacy restore
// - legacy restore test: privileged restores, user nothing
// - fetch and internal cycle counts per variant
// - opcode selects sixteen operations in order
// - logical flags: carry from shifter, overflow kept
// - arithmetic flags: adder carry and overflow
// - rotate-by-zero encoding rotates through carry
module data_processing_unit (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // instruction issue
   input wire logic issue,
   input wire logic [31:0] instr,
   input wire logic [31:0] instr_addr,
   // register file read data
   input wire logic [31:0] first_operand_register,
   input wire logic [31:0] second_operand_register,
   input wire logic [31:0] shift_amount_register,
   // status words
   input wire logic [31:0] saved_status_word,
   input wire logic status_load,
   input wire logic [31:0] status_load_value,
   // progress
   output logic busy,
   output logic fetch,
   output logic internal_cycle,
   output logic done,
   output logic not_data_op,
   output logic illegal_amount_source,
   // results
   output logic dest_write,
   output logic [3:0] dest_index,
   output logic [31:0] dest_value,
   output logic pc_write,
   output logic [31:0] pc_value,
   output logic [31:0] current_status_word
);

   dp_pkg::dp_state_e state_q, state_d;
   logic [31:0] instr_q;
   logic [31:0] op1_q;
   logic [31:0] op2_q;
   logic [7:0] amount_q;
   logic [1:0] refill_q, refill_d;
   logic [31:0] status_q, status_d;
   logic busy_q, fetch_q, internal_q, done_q, not_data_q, illegal_q;
   logic dest_write_q, pc_write_q;
   logic [3:0] dest_index_q;
   logic [31:0] result_q;

   // ----------------------------------------------------------------------
   // issue-time decode and program counter view
   // ----------------------------------------------------------------------
   logic in_reg_shift, in_mul_sel, in_amount_pc, accept, start;
   logic [31:0] pc_view, op1_in, op2_in;

   assign in_reg_shift = !instr[dp_pkg::IMM_BIT] &&
                         instr[dp_pkg::REG_SHIFT_BIT];
   assign in_mul_sel = in_reg_shift && instr[dp_pkg::MUL_SEL_BIT];
   assign in_amount_pc = in_reg_shift &&
      instr[dp_pkg::AMT_REG_HI:dp_pkg::AMT_REG_LO] == dp_pkg::PC_INDEX;
   assign accept = issue && (state_q == dp_pkg::ST_IDLE);
   assign start = accept && !in_mul_sel && !in_amount_pc;
   assign pc_view = instr_addr + (in_reg_shift ? dp_pkg::PC_AHEAD_REG
                                               : dp_pkg::PC_AHEAD_IMM);
   assign op1_in = (instr[dp_pkg::FIRST_HI:dp_pkg::FIRST_LO] ==
                    dp_pkg::PC_INDEX) ? pc_view : first_operand_register;
   assign op2_in = (instr[dp_pkg::SECOND_HI:dp_pkg::SECOND_LO] ==
                    dp_pkg::PC_INDEX) ? pc_view : second_operand_register;

   // ----------------------------------------------------------------------
   // latched instruction fields
   // ----------------------------------------------------------------------
   logic use_imm, reg_shift, set_bit, test_op, logical, dest_is_pc;
   logic legacy_restore, privileged, writes_pc, flags_update, restore;
   logic [3:0] opcode;
   logic [3:0] dest_idx;
   logic [1:0] enc_kind;
   logic [4:0] enc_amount;

   assign use_imm = instr_q[dp_pkg::IMM_BIT];
   assign reg_shift = !use_imm && instr_q[dp_pkg::REG_SHIFT_BIT];
   assign opcode = instr_q[dp_pkg::OPC_HI:dp_pkg::OPC_LO];
   assign set_bit = instr_q[dp_pkg::SET_BIT];
   assign dest_idx = instr_q[dp_pkg::DEST_HI:dp_pkg::DEST_LO];
   assign enc_kind = instr_q[dp_pkg::KIND_HI:dp_pkg::KIND_LO];
   assign enc_amount = instr_q[dp_pkg::SHAMT_HI:dp_pkg::SHAMT_LO];
   assign dest_is_pc = dest_idx == dp_pkg::PC_INDEX;
   assign test_op = opcode[3:2] == dp_pkg::TEST_GROUP;
   assign logical = test_op ? !opcode[1]
      : (opcode[3] || opcode == dp_pkg::OPC_AND ||
         opcode == dp_pkg::OPC_XOR);
   assign privileged = status_q[dp_pkg::MODE_HI:dp_pkg::MODE_LO] !=
                       dp_pkg::MODE_USER;
   assign legacy_restore = opcode == dp_pkg::OPC_TEST_EQUIV && set_bit &&
                           dest_is_pc;
   assign writes_pc = dest_is_pc && !test_op;
   // test opcodes behave as if the set bit were present
   assign flags_update = test_op ? !legacy_restore
                                 : (set_bit && !dest_is_pc);
   assign restore = (writes_pc && set_bit) ||
                    (legacy_restore && privileged);

   // ----------------------------------------------------------------------
   // shifter operand selection
   // ----------------------------------------------------------------------
   logic [31:0] sh_value;
   logic [1:0] sh_kind;
   logic [7:0] sh_amount;
   logic sh_extend, sh_carry;
   logic [31:0] op2;
   logic enc_zero;

   assign enc_zero = enc_amount == 5'h00;
   assign sh_value = use_imm ? {24'h00_0000,
      instr_q[dp_pkg::IMM8_HI:dp_pkg::IMM8_LO]} : op2_q;
   assign sh_kind = use_imm ? dp_pkg::SHIFT_ROTATE : enc_kind;
   // encoded right and arithmetic by zero stand for a full word
   assign sh_amount = use_imm ?
      {3'h0, instr_q[dp_pkg::ROT_HI:dp_pkg::ROT_LO], 1'b0}
      : reg_shift ? amount_q
      : (enc_zero && (enc_kind == dp_pkg::SHIFT_RIGHT ||
                      enc_kind == dp_pkg::SHIFT_ARITH))
         ? dp_pkg::SHIFT_FULL_WORD : {3'h0, enc_amount};
   assign sh_extend = !use_imm && !reg_shift && enc_zero &&
                      enc_kind == dp_pkg::SHIFT_ROTATE;

   barrel_shifter u_shifter (
      .value(sh_value),
      .kind(sh_kind),
      .amount(sh_amount),
      .extend(sh_extend),
      .carry_in(status_q[dp_pkg::FLAG_C]),
      .result(op2),
      .carry_out(sh_carry)
   );

   // ----------------------------------------------------------------------
   // alu
   // ----------------------------------------------------------------------
   logic [31:0] add_x, add_y, logic_res, result;
   logic add_ci, carry_now;
   logic [32:0] sum;
   logic add_v;

   assign carry_now = status_q[dp_pkg::FLAG_C];

   always_comb begin
      add_x = op1_q;
      add_y = op2;
      add_ci = 1'b0;
      logic_res = op1_q & op2;
      case (opcode)
         dp_pkg::OPC_AND, dp_pkg::OPC_TEST_BITS: logic_res = op1_q & op2;
         dp_pkg::OPC_XOR, dp_pkg::OPC_TEST_EQUIV: logic_res = op1_q ^ op2;
         dp_pkg::OPC_SUB, dp_pkg::OPC_COMPARE: begin
            add_y = ~op2;
            add_ci = 1'b1;
         end
         dp_pkg::OPC_RSUB: begin
            add_x = op2;
            add_y = ~op1_q;
            add_ci = 1'b1;
         end
         dp_pkg::OPC_ADD, dp_pkg::OPC_COMPARE_NEG: add_ci = 1'b0;
         dp_pkg::OPC_ADDC: add_ci = carry_now;
         dp_pkg::OPC_SUBC: begin
            add_y = ~op2;
            add_ci = carry_now;
         end
         dp_pkg::OPC_RSUBC: begin
            add_x = op2;
            add_y = ~op1_q;
            add_ci = carry_now;
         end
         dp_pkg::OPC_OR: logic_res = op1_q | op2;
         dp_pkg::OPC_MOVE: logic_res = op2;
         dp_pkg::OPC_BIT_CLEAR: logic_res = op1_q & ~op2;
         dp_pkg::OPC_MOVE_NOT: logic_res = ~op2;
         default: logic_res = op1_q & op2;
      endcase
   end

   assign sum = {1'b0, add_x} + {1'b0, add_y} + {32'h0000_0000, add_ci};
   assign add_v = (add_x[31] == add_y[31]) && (sum[31] != add_x[31]);
   assign result = logical ? logic_res : sum[31:0];

   // ----------------------------------------------------------------------
   // status word update
   // ----------------------------------------------------------------------
   logic exec_now;
   logic [3:0] new_flags;

   assign exec_now = state_q == dp_pkg::ST_EXEC;
   assign new_flags = {result[31], result == 32'h0000_0000,
      logical ? sh_carry : sum[32],
      logical ? status_q[dp_pkg::FLAG_V] : add_v};

   always_comb begin
      status_d = status_q;
      if (exec_now && restore) begin
         status_d = saved_status_word;
      end else if (exec_now && flags_update) begin
         status_d[dp_pkg::FLAG_N:dp_pkg::FLAG_V] = new_flags;
      end else if (status_load) begin
         status_d = status_load_value;
      end
   end

   // ----------------------------------------------------------------------
   // sequencing: internal cycle, execute fetch, refill fetches
   // ----------------------------------------------------------------------
   logic finish;

   always_comb begin
      state_d = state_q;
      refill_d = refill_q;
      finish = 1'b0;
      case (state_q)
         dp_pkg::ST_IDLE: begin
            if (start) begin
               state_d = in_reg_shift ? dp_pkg::ST_INTERNAL
                                      : dp_pkg::ST_EXEC;
            end
         end
         dp_pkg::ST_INTERNAL: state_d = dp_pkg::ST_EXEC;
         dp_pkg::ST_EXEC: begin
            if (writes_pc) begin
               state_d = dp_pkg::ST_REFILL;
               refill_d = dp_pkg::REFILL_CYCLES;
            end else begin
               state_d = dp_pkg::ST_IDLE;
               finish = 1'b1;
            end
         end
         dp_pkg::ST_REFILL: begin
            refill_d = refill_q - 2'h1;
            if (refill_q == dp_pkg::REFILL_LAST) begin
               state_d = dp_pkg::ST_IDLE;
               finish = 1'b1;
            end
         end
         default: state_d = dp_pkg::ST_IDLE;
      endcase
   end

   // ----------------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= dp_pkg::ST_IDLE;
         refill_q <= 2'h0;
         status_q <= dp_pkg::STATUS_RESET;
      end else begin
         state_q <= state_d;
         refill_q <= refill_d;
         status_q <= status_d;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         instr_q <= 32'h0000_0000;
         op1_q <= 32'h0000_0000;
         op2_q <= 32'h0000_0000;
         amount_q <= 8'h00;
      end else if (start) begin
         instr_q <= instr;
         op1_q <= op1_in;
         op2_q <= op2_in;
         amount_q <= shift_amount_register[7:0];
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         busy_q <= 1'b0;
         fetch_q <= 1'b0;
         internal_q <= 1'b0;
         done_q <= 1'b0;
         not_data_q <= 1'b0;
         illegal_q <= 1'b0;
      end else begin
         busy_q <= state_d != dp_pkg::ST_IDLE;
         fetch_q <= state_d == dp_pkg::ST_EXEC ||
                    state_d == dp_pkg::ST_REFILL;
         internal_q <= state_d == dp_pkg::ST_INTERNAL;
         done_q <= finish;
         not_data_q <= accept && in_mul_sel;
         illegal_q <= accept && !in_mul_sel && in_amount_pc;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         dest_write_q <= 1'b0;
         pc_write_q <= 1'b0;
         dest_index_q <= 4'h0;
         result_q <= 32'h0000_0000;
      end else begin
         dest_write_q <= exec_now && !test_op && !dest_is_pc;
         pc_write_q <= exec_now && writes_pc;
         if (exec_now) begin
            dest_index_q <= dest_idx;
            result_q <= result;
         end
      end
   end

   // ----------------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------------
   assign busy = busy_q;
   assign fetch = fetch_q;
   assign internal_cycle = internal_q;
   assign done = done_q;
   assign not_data_op = not_data_q;
   assign illegal_amount_source = illegal_q;
   assign dest_write = dest_write_q;
   assign dest_index = dest_index_q;
   assign dest_value = result_q;
   assign pc_write = pc_write_q;
   assign pc_value = result_q;
   assign current_status_word = status_q;

endmodule

/* testbench/dp_monitor.sv */
// checker for the data processing datapath: issue to done sequencing
// assumes it is bound onto data_processing_unit
`timescale 1ns/10ps
module dp_monitor (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // watched ports
   input wire logic issue,
   input wire logic [31:0] instr,
   input wire logic busy,
   input wire logic fetch,
   input wire logic internal_cycle,
   input wire logic done,
   input wire logic not_data_op,
   input wire logic illegal_amount_source,
   input wire logic dest_write,
   input wire logic pc_write,
   input wire logic status_load,
   input wire logic [31:0] current_status_word
);
   // ----------
   // issue classes
   // ----------
   wire logic take = issue && !busy;
   wire logic rsh = !instr[25] && instr[4];
   wire logic nd = rsh && instr[7];
   wire logic bad = rsh && !instr[7] && instr[11:8] == 4'hf;
   wire logic tst = instr[24:23] == 2'h2;
   wire logic pcw = instr[15:12] == 4'hf && !tst;
   wire logic ok = take && !nd && !bad;
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   sequence seq_norm;
      fetch && !internal_cycle ##1 done && !fetch;
   endsequence
   sequence seq_reg;
      internal_cycle && !fetch ##1 fetch ##1 done;
   endsequence
   sequence seq_pcw;
      fetch ##1 fetch && pc_write ##1 fetch ##1 done;
   endsequence
   chk_norm_timing: assert property (
      ok && !rsh && !pcw |=> seq_norm) else $error("normal timing");
   chk_reg_timing: assert property (
      ok && rsh && !pcw |=> seq_reg) else $error("reg shift timing");
   chk_pc_timing: assert property (
      ok && !rsh && pcw |=> seq_pcw) else $error("pc write timing");
   chk_regpc_timing: assert property (
      ok && rsh && pcw |=> internal_cycle ##1 seq_pcw)
      else $error("reg pc timing");
   chk_not_data: assert property (
      take && nd |=> not_data_op && !busy && !fetch)
      else $error("bit 7 word not refused");
   chk_bad_source: assert property (
      take && bad |=> illegal_amount_source && !busy)
      else $error("pc amount source not refused");
   chk_test_nowrite: assert property (
      ok && tst |=> (!dest_write && !pc_write) [*3])
      else $error("test opcode wrote");
   chk_status_cause: assert property (
      $changed(current_status_word) |-> done || pc_write ||
      $past(status_load)) else $error("status changed without cause");
   chk_done_pulse: assert property (
      done |=> !done && (!busy || $past(issue)))
      else $error("done not a pulse");
endmodule
bind data_processing_unit dp_monitor u_mon (.clk, .reset_n, .issue,
   .instr, .busy, .fetch, .internal_cycle, .done, .not_data_op,
   .illegal_amount_source, .dest_write, .pc_write, .status_load,
   .current_status_word);

/* testbench/tb_data_processing_unit.sv */
// self-checking bench for data_processing_unit with a reference model
// assumes dp_pkg, the design and dp_monitor are compiled first
`timescale 1ns/10ps
`define CHK(n, e, g) begin check_count++; if ((e) !== (g)) begin \
   n_errors++; $display("FAIL %s exp %h got %h", n, e, g); end end
module tb_data_processing_unit;
   logic clk = 0, reset_n = 0, issue = 0, status_load = 0;
   logic [31:0] instr = 0, instr_addr = 0, op_a = 0, op_b = 0, op_s = 0;
   logic [31:0] saved = 0, load_val = 0, exp_csw, dest_value, pc_value, csw;
   logic busy, fetch, internal_cycle, done, not_data_op, illegal_src;
   logic dest_write, pc_write;
   logic [3:0] dest_index;
   logic [7:0] amts [7] = '{8'h00, 8'h01, 8'h1f, 8'h20, 8'h21, 8'h41, 8'hff};
   int n_errors = 0, check_count = 0, seed = 55;
   initial forever #20 clk = ~clk;
   data_processing_unit dut (.clk, .reset_n, .issue, .instr, .instr_addr,
      .first_operand_register(op_a), .second_operand_register(op_b),
      .shift_amount_register(op_s), .saved_status_word(saved),
      .status_load, .status_load_value(load_val), .busy, .fetch,
      .internal_cycle, .done, .not_data_op,
      .illegal_amount_source(illegal_src), .dest_write, .dest_index,
      .dest_value, .pc_write, .pc_value, .current_status_word(csw));
   // ----------
   // reference model
   // ----------
   function automatic logic [32:0] shift_ref(input logic [31:0] v,
      input logic [1:0] k, input logic [7:0] n, input logic c);
      logic [32:0] t;
      logic [31:0] r;
      int m;
      t = {c, v};
      m = (n + 31) % 32 + 1;
      if (n != 0) begin
         case (k)
            2'h0: t = {1'b0, v} << n;
            2'h1: t = {v, 1'b0} >> n;
            2'h2: t = $signed({v, 1'b0}) >>> (n > 32 ? 32 : n);
            default: begin
               r = (v >> m) | (v << (32 - m));
               t = {r, r[31]};
            end
         endcase
         if (k != 2'h0) t = {t[0], t[32:1]};
      end
      return t;
   endfunction
   task automatic model(input logic [31:0] i, a0, b0, s, ad, sv,
      output logic [31:0] y, output int cyc, fch, output logic wr, pw);
      logic rs, lg, tst, ci, c0, cf, vf;
      logic [31:0] pcv, a, b, x, z;
      logic [32:0] t, u;
      logic [7:0] n;
      logic [1:0] k;
      rs = !i[25] && i[4];
      k = i[6:5];
      c0 = exp_csw[29];
      pcv = ad + (rs ? 32'h0000_000c : 32'h0000_0008);
      a = i[19:16] == 4'hf ? pcv : a0;
      b = i[3:0] == 4'hf ? pcv : b0;
      n = rs ? s[7:0] : {3'h0, i[11:7]};
      if (i[25]) t = shift_ref({24'h0, i[7:0]}, 2'h3, {i[11:8], 1'b0}, c0);
      else if (!rs && n == 0 && k == 2'h3) t = {b[0], c0, b[31:1]};
      else if (!rs && n == 0 && k != 2'h0) t = shift_ref(b, k, 8'h20, c0);
      else t = shift_ref(b, k, n, c0);
      lg = 1;
      ci = 0;
      x = a;
      z = t[31:0];
      case (i[24:21])
         4'h0, 4'h8: y = a & z;
         4'h1, 4'h9: y = a ^ z;
         4'hc: y = a | z;
         4'hd: y = z;
         4'he: y = a & ~z;
         4'hf: y = ~z;
         4'h2, 4'ha: {lg, z, ci} = {1'b0, ~z, 1'b1};
         4'h3: {lg, x, z, ci} = {1'b0, z, ~a, 1'b1};
         4'h4, 4'hb: lg = 0;
         4'h5: {lg, ci} = {1'b0, c0};
         4'h6: {lg, z, ci} = {1'b0, ~z, c0};
         default: {lg, x, z, ci} = {1'b0, z, ~a, c0};
      endcase
      u = {1'b0, x} + {1'b0, z} + ci;
      if (!lg) y = u[31:0];
      cf = lg ? t[32] : u[32];
      vf = lg ? exp_csw[28] : x[31] == z[31] && y[31] != x[31];
      tst = i[24:23] == 2'h2;
      wr = !tst && i[15:12] != 4'hf;
      pw = !tst && i[15:12] == 4'hf;
      cyc = (pw ? 4 : 2) + rs;
      fch = pw ? 3 : 1;
      if (tst && i[24:21] == 4'h9 && i[15:12] == 4'hf) begin
         if (exp_csw[4:0] != 5'h10) exp_csw = sv;
      end else if (pw && i[20]) exp_csw = sv;
      else if (i[20] || tst) exp_csw[31:28] = {y[31], y == 0, cf, vf};
   endtask
   // ----------
   // drivers and verdict
   // ----------
   task automatic give_verdict;
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic load_status(input logic [31:0] v);
      @(posedge clk);
      status_load <= 1;
      load_val <= v;
      @(posedge clk);
      status_load <= 0;
      exp_csw = v;
   endtask
   task automatic run(input logic [31:0] i, a, b, s);
      logic [31:0] r, ad, sv;
      logic wr, pw, rf;
      logic gw = 0, gp = 0;
      int cyc, fch, k, dk = 0, nf = 0;
      ad = $random(seed) & 32'hffff_fffc;
      sv = $random(seed);
      rf = !i[25] && i[4] && (i[7] || i[11:8] == 4'hf);
      if (!rf) model(i, a, b, s, ad, sv, r, cyc, fch, wr, pw);
      @(posedge clk);
      issue <= 1;
      instr <= i;
      op_a <= a;
      op_b <= b;
      op_s <= s;
      instr_addr <= ad;
      saved <= sv;
      @(posedge clk);
      issue <= 0;
      for (k = 1; k < 9 && dk == 0; k++) begin
         #1;
         nf += fetch;
         gw |= dest_write;
         gp |= pc_write;
         if ((done | not_data_op | illegal_src) === 1'b1) dk = k;
         else @(posedge clk);
      end
      if (dk == 0) begin
         n_errors++;
         $display("FAIL completion exp 1 got 0");
         give_verdict;
      end
      if (rf) begin
         `CHK("not_data_op", i[7], not_data_op)
         `CHK("amount_source", !i[7], illegal_src)
         `CHK("refused_write", 2'h0, {gw, gp})
      end else begin
         `CHK("cycles", cyc, dk)
         `CHK("fetches", fch, nf)
         `CHK("dest_write", wr, gw)
         `CHK("pc_write", pw, gp)
         if (wr) `CHK("dest_index", i[15:12], dest_index)
         if (wr) `CHK("dest_value", r, dest_value)
         if (pw) `CHK("pc_value", r, pc_value)
      end
      `CHK("status_word", exp_csw, csw)
   endtask
   // ----------
   // scenarios
   // ----------
   initial begin
      int k, j, m;
      logic [31:0] w;
      exp_csw = 32'h0000_00d3;
      repeat (20) @(posedge clk);
      reset_n <= 1;
      `CHK("reset_status", exp_csw, csw)
      for (k = 0; k < 4; k++) begin
         for (j = 0; j < 7; j++) begin
            w = {12'he1b, 8'h01, 4'h3, 1'b0, k[1:0], 1'b1, 4'h2};
            run(w, 0, $random(seed), ($random(seed) & 32'hffff_ff00) |
               amts[j]);
         end
         for (j = 0; j < 32; j += 31) begin
            w = {12'he1b, 8'h01, j[4:0], k[1:0], 1'b0, 4'h2};
            run(w, 0, $random(seed), 0);
         end
      end
      for (j = 0; j < 16; j++) begin
         run({12'he3b, 8'h01, j[3:0], 8'h81}, 0, 0, 0);
         for (m = 0; m < 2; m++) begin
            w = {7'h70, j[3:0], m[0] | (j[3:2] == 2'h2), 8'h45, 12'h006};
            run(w, $random(seed), $random(seed), 0);
         end
      end
      run({12'he08, 8'hf1, 4'h3, 4'h1, 4'hf}, 0, 0, 4);
      run({12'he08, 8'hf1, 12'h00f}, 0, 0, 0);
      for (j = 0; j < 4; j++) begin
         w = {11'h70d, j[0], 8'h0f, 4'h3, 3'h2, j[1], 4'h2};
         run(w, 0, $random(seed), 3);
      end
      load_status(32'h0000_00d3);
      run({11'h709, 1'b1, 8'h1f, 12'h002}, 1, 2, 0);
      load_status(32'h5000_0010);
      run({11'h709, 1'b1, 8'h1f, 12'h002}, 1, 2, 0);
      run({12'he08, 8'h12, 4'h3, 4'h9, 4'h4}, 1, 2, 3);
      run({12'he08, 8'h12, 4'hf, 4'h1, 4'h4}, 1, 2, 3);
      for (k = 0; k < 150; k++) begin
         w = $random(seed);
         w[27:26] = 2'h0;
         w[7] = w[7] & (w[25] | ~w[4]);
         if (w[11:8] == 4'hf) w[11] = 0;
         w[20] = w[20] | (w[24:23] == 2'h2);
         run(w, $random(seed), $random(seed), $random(seed) & 32'h0000_003f);
      end
      give_verdict;
   end
endmodule
